// ===== rtl/aac_pkg.sv
// Constants for the add, AND and call execution unit.
// Assumes an 8-bit core with 16-bit program counter and 8-bit register space.
package aac_pkg;
  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_ADD_RR = 8'h02;
  localparam logic [7:0] OP_ADD_RI = 8'h03;
  localparam logic [7:0] OP_ADD_GG = 8'h04;
  localparam logic [7:0] OP_ADD_GI = 8'h05;
  localparam logic [7:0] OP_ADD_GL = 8'h06;
  localparam logic [7:0] OP_AND_RR = 8'h52;
  localparam logic [7:0] OP_AND_RI = 8'h53;
  localparam logic [7:0] OP_AND_GG = 8'h54;
  localparam logic [7:0] OP_AND_GI = 8'h55;
  localparam logic [7:0] OP_AND_GL = 8'h56;
  localparam logic [7:0] OP_CALL_DIR = 8'hF6;
  localparam logic [7:0] OP_CALL_PAIR = 8'hF4;
  localparam logic [7:0] OP_EXIT = 8'hAF;
  // ----------------------------------------------------------------
  // Cycle counts and lengths
  // ----------------------------------------------------------------
  localparam logic [3:0] CYC_SHORT = 4'h4;
  localparam logic [3:0] CYC_LONG = 4'h6;
  localparam logic [3:0] CYC_CALL_DIR = 4'hE;
  localparam logic [3:0] CYC_CALL_PAIR = 4'hC;
  localparam logic [3:0] CYC_EXIT = 4'h8;
  localparam logic [15:0] LEN_2 = 16'h0002;
  localparam logic [15:0] LEN_3 = 16'h0003;
  localparam logic [15:0] LEN_1 = 16'h0001;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] FLAGS_ADDR = 8'hD5;
  localparam logic [7:0] WREG_BASE = 8'hC0;
  localparam logic [7:0] SP_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [31:0] BUS_ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] BUS_ADDR_PC = 32'h0000_0004;
  localparam logic [31:0] BUS_ADDR_FLAGS = 32'h0000_0008;
  localparam logic [31:0] BUS_ADDR_SP = 32'h0000_000C;
  localparam logic [31:0] BUS_ADDR_REGS = 32'h0000_0400;
  localparam logic [31:0] BUS_ADDR_PROG = 32'h0001_0000;
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  // ----------------------------------------------------------------
  // Execution states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_FETCH = 6'b000010,
    ST_OPER = 6'b000100,
    ST_EXEC = 6'b001000,
    ST_PUSH = 6'b010000,
    ST_WAIT = 6'b100000
  } aac_state_t;
endpackage

// ===== rtl/aac_core.sv
// Execution unit for add, AND, call and procedure exit of an 8-bit core.
// Assumes software loads program bytes and registers over AHB-Lite, then runs.
//
// Operation
// (RL1) Add source into destination; source kept
// (RL2) Add sets carry from bit seven
// (RL3) Add sets overflow on sign change
// (RL4) Add sets zero and sign flags
// (RL5) Add opcodes 02 to 06 decoded
// (RL6) Three-byte operand order per encoding
// (RL7) AND writes bitwise AND; source kept
// (RL8) AND keeps carry, clears overflow
// (RL9) AND opcodes 52 to 56 decoded
// (RL10) Call pushes low then high byte
// (RL11) Pushed address follows call encoding
// (RL12) Call loads target into program counter
// (RL13) Call opcodes F6 and F4 decoded
// (RL14) Procedure exit pops program counter
// (RL15) Call leaves all flags unchanged
// (RL16) Flags register at address D5
// (RL17) Indirect forms use pointer register
// (RL18) Program counter is sixteen bits
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/100ps
module aac_core
  import aac_pkg::*;
#(
  parameter int PROG_DEPTH = 256
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic busy_r
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] prog_r [PROG_DEPTH];
  logic [7:0] regs_r [256];
  logic [15:0] pc_r;
  logic [7:0] flags_r;
  logic [7:0] sp_r;
  aac_state_t state_r;
  logic [3:0] cnt_r;
  logic [7:0] op_r, b1_r, b2_r;
  logic [7:0] dst_a_r, src_v_r, res_r;
  logic [15:0] ret_r, tgt_r;
  logic [7:0] fl_nxt;
  logic wr_dst_r;
  logic ph_wr_r, ph_sel_r;
  logic [31:0] ph_addr_r;
  logic start_pls;

  function automatic logic [7:0] pbyte(input logic [15:0] a);
    pbyte = prog_r[a[$clog2(PROG_DEPTH)-1:0]];
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_sel_r <= 1'b0;
      ph_wr_r <= 1'b0;
      ph_addr_r <= 32'h0000_0000;
    end else if (clk_en && hready) begin
      ph_sel_r <= hsel && htrans[1];
      ph_wr_r <= hwrite;
      ph_addr_r <= haddr;
    end
  end

  assign start_pls = clk_en && ph_sel_r && ph_wr_r && ph_addr_r == BUS_ADDR_CTRL && hwdata[0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hsel && htrans[1] && !hwrite && hready) begin
        if (haddr == BUS_ADDR_CTRL) begin
          hrdata <= {31'h0000_0000, busy_r};
        end else if (haddr == BUS_ADDR_PC) begin
          hrdata <= {16'h0000, pc_r};
        end else if (haddr == BUS_ADDR_FLAGS) begin
          hrdata <= {24'h00_0000, flags_r};
        end else if (haddr == BUS_ADDR_SP) begin
          hrdata <= {24'h00_0000, sp_r};
        end else if (haddr[31:10] == BUS_ADDR_REGS[31:10]) begin
          hrdata <= {24'h00_0000, regs_r[haddr[9:2]]};
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end

  // Program bytes: one per word, software writes taken in any state, busy or idle.
  always_ff @(posedge hclk) begin
    if (clk_en && ph_sel_r && ph_wr_r && ph_addr_r[31:16] == BUS_ADDR_PROG[31:16]) begin
      prog_r[ph_addr_r[$clog2(PROG_DEPTH)+1:2]] <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Decode and operand fetch
  // ----------------------------------------------------------------
  logic is_add, is_and, is_call, is_exit, is_short, is_ind, is_lit;
  logic [3:0] cyc_need;
  logic [15:0] len;
  always_comb begin
    is_add = op_r inside {OP_ADD_RR, OP_ADD_RI, OP_ADD_GG, OP_ADD_GI, OP_ADD_GL}; // [RL5]
    is_and = op_r inside {OP_AND_RR, OP_AND_RI, OP_AND_GG, OP_AND_GI, OP_AND_GL}; // [RL9]
    is_call = op_r == OP_CALL_DIR || op_r == OP_CALL_PAIR; // [RL13]
    is_exit = op_r == OP_EXIT;
    is_short = op_r[3:0] == OP_ADD_RR[3:0] || op_r[3:0] == OP_ADD_RI[3:0];
    is_ind = op_r[3:0] == OP_ADD_RI[3:0] || op_r[3:0] == OP_ADD_GI[3:0];
    is_lit = op_r[3:0] == OP_ADD_GL[3:0];
    if (is_call) begin
      cyc_need = (op_r == OP_CALL_DIR) ? CYC_CALL_DIR : CYC_CALL_PAIR; // [RL13]
      len = (op_r == OP_CALL_DIR) ? LEN_3 : LEN_2; // [RL11]
    end else if (is_exit) begin
      cyc_need = CYC_EXIT;
      len = LEN_1;
    end else begin
      cyc_need = (op_r[3:0] == OP_ADD_RR[3:0]) ? CYC_SHORT : CYC_LONG; // [RL5] [RL9]
      len = is_short ? LEN_2 : LEN_3;
    end
  end

  // Operand addresses: short forms name working registers in nibbles.
  logic [7:0] dst_a, src_a, src_v;
  always_comb begin
    if (is_short) begin
      dst_a = WREG_BASE | {4'h0, b1_r[7:4]};
      src_a = WREG_BASE | {4'h0, b1_r[3:0]};
    end else if (is_lit) begin
      dst_a = b1_r; // [RL6]
      src_a = b2_r;
    end else begin
      dst_a = b2_r; // [RL6]
      src_a = b1_r;
    end
    src_v = is_lit ? b2_r : (is_ind ? regs_r[regs_r[src_a]] : regs_r[src_a]); // [RL17]
  end

  // ----------------------------------------------------------------
  // Arithmetic and flags
  // ----------------------------------------------------------------
  logic [8:0] sum;
  logic [7:0] dv, land;
  always_comb begin
    dv = regs_r[dst_a_r];
    sum = {1'b0, dv} + {1'b0, src_v_r}; // [RL1]
    land = dv & src_v_r; // [RL7]
    fl_nxt = flags_r;
    if (is_add) begin
      fl_nxt[FLAG_C] = sum[8]; // [RL2]
      fl_nxt[FLAG_Z] = sum[7:0] == 8'h00; // [RL4]
      fl_nxt[FLAG_S] = sum[7];
      fl_nxt[FLAG_V] = (dv[7] == src_v_r[7]) && (sum[7] != dv[7]); // [RL3]
    end else if (is_and) begin
      fl_nxt[FLAG_Z] = land == 8'h00; // [RL8]
      fl_nxt[FLAG_S] = land[7];
      fl_nxt[FLAG_V] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      op_r <= 8'h00;
      b1_r <= 8'h00;
      b2_r <= 8'h00;
      dst_a_r <= 8'h00;
      src_v_r <= 8'h00;
      res_r <= 8'h00;
      ret_r <= PC_RESET;
      tgt_r <= PC_RESET;
      pc_r <= PC_RESET;
      sp_r <= SP_RESET;
      flags_r <= 8'h00;
      wr_dst_r <= 1'b0;
    end else if (clk_en) begin
      wr_dst_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start_pls) begin
            busy_r <= 1'b1;
            state_r <= ST_FETCH;
          end else if (ph_sel_r && ph_wr_r) begin
            if (ph_addr_r == BUS_ADDR_PC) pc_r <= hwdata[15:0];
            else if (ph_addr_r == BUS_ADDR_SP) sp_r <= hwdata[7:0];
            else if (ph_addr_r == BUS_ADDR_FLAGS) flags_r <= hwdata[7:0];
          end
        end
        ST_FETCH: begin
          op_r <= pbyte(pc_r);
          b1_r <= pbyte(pc_r + LEN_1);
          b2_r <= pbyte(pc_r + LEN_2);
          cnt_r <= 4'h1;
          state_r <= ST_OPER;
        end
        ST_OPER: begin
          dst_a_r <= dst_a;
          src_v_r <= src_v;
          ret_r <= pc_r + len; // [RL11] [RL18]
          if (op_r == OP_CALL_DIR) tgt_r <= {b1_r, b2_r}; // [RL12]
          else tgt_r <= {regs_r[b1_r & 8'hFE], regs_r[b1_r | 8'h01]}; // [RL17]
          cnt_r <= cnt_r + 4'h1;
          if (is_add || is_and || is_call || is_exit) state_r <= ST_EXEC;
          else begin
            busy_r <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        ST_EXEC: begin
          cnt_r <= cnt_r + 4'h1;
          if (is_call) begin
            sp_r <= sp_r - 8'h01; // [RL10]
            res_r <= ret_r[7:0];
            wr_dst_r <= 1'b1;
            dst_a_r <= sp_r - 8'h01;
            state_r <= ST_PUSH;
          end else if (is_exit) begin
            pc_r <= {regs_r[sp_r], regs_r[sp_r + 8'h01]}; // [RL14]
            sp_r <= sp_r + 8'h02;
            state_r <= ST_WAIT;
          end else begin
            res_r <= is_add ? sum[7:0] : land; // [RL1] [RL7]
            wr_dst_r <= 1'b1;
            flags_r <= fl_nxt; // [RL16]
            pc_r <= ret_r;
            state_r <= ST_WAIT;
          end
        end
        ST_PUSH: begin
          cnt_r <= cnt_r + 4'h1;
          sp_r <= sp_r - 8'h01; // [RL10]
          res_r <= ret_r[15:8];
          wr_dst_r <= 1'b1;
          dst_a_r <= sp_r - 8'h01;
          pc_r <= tgt_r; // [RL12] [RL15]
          state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r >= cyc_need - 4'h1) begin
            busy_r <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Register file: bus writes when idle, execution writes otherwise.
  always_ff @(posedge hclk) begin
    if (clk_en) begin
      if (wr_dst_r) begin
        regs_r[dst_a_r] <= res_r;
      end else if (!busy_r && ph_sel_r && ph_wr_r
                   && ph_addr_r[31:10] == BUS_ADDR_REGS[31:10]) begin
        regs_r[ph_addr_r[9:2]] <= hwdata[7:0];
      end
      if (state_r == ST_EXEC && (is_add || is_and)) begin
        regs_r[FLAGS_ADDR] <= fl_nxt; // [RL16]
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_call_exec;
    state_r == ST_EXEC && is_call;
  endsequence
  property p_push_low;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en and s_call_exec) |=> res_r == $past(ret_r[7:0]) && wr_dst_r;
  endproperty
  a_push_low: assert property (p_push_low) else $error("call low byte push wrong"); // [RL10]
  property p_call_flags;
    @(posedge hclk) disable iff (!hresetn)
      state_r == ST_OPER && is_call |=> flags_r == $past(flags_r);
  endproperty
  a_call_flags: assert property (p_call_flags) else $error("call changed flags"); // [RL15]
  property p_and_v;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && state_r == ST_EXEC && is_and |=> !flags_r[FLAG_V];
  endproperty
  a_and_v: assert property (p_and_v) else $error("AND left overflow set"); // [RL8]
  property p_add_c;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && state_r == ST_EXEC && is_add |=> flags_r[FLAG_C] == $past(sum[8]);
  endproperty
  a_add_c: assert property (p_add_c) else $error("add carry wrong"); // [RL2]
  property p_add_z;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && state_r == ST_EXEC && is_add |=> flags_r[FLAG_Z] == (res_r == 8'h00);
  endproperty
  a_add_z: assert property (p_add_z) else $error("add zero flag wrong"); // [RL4]
  property p_call_pc;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && state_r == ST_PUSH |=> pc_r == $past(tgt_r);
  endproperty
  a_call_pc: assert property (p_call_pc) else $error("call target not loaded"); // [RL12]
  property p_add_res;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && state_r == ST_EXEC && is_add |=> res_r == $past(sum[7:0]);
  endproperty
  a_add_res: assert property (p_add_res) else $error("add result wrong"); // [RL1]
  property p_ret_len;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && state_r == ST_OPER && op_r == OP_CALL_DIR |=> ret_r == $past(pc_r) + LEN_3;
  endproperty
  a_ret_len: assert property (p_ret_len) else $error("return address wrong"); // [RL11]
endmodule

// ===== tb/aac_host_model.sv
// AHB-Lite master standing in for the software that loads and runs the core.
// Assumes a single slave whose hreadyout is fed back as the bus hready.
`timescale 1ns/100ps
module aac_host_model (
  input wire logic hclk,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // Released lines show inverted values so stale data cannot pass for fresh.
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
    haddr <= ~a;
    hwdata <= ~wd;
  endtask
endmodule

// ===== tb/test_add_and_call_execution.sv
// Self-checking bench for the add, AND, call and procedure exit unit.
// Assumes the core is loaded and started over AHB-Lite by the host model.
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module test_add_and_call_execution;
  import aac_pkg::*;
  logic hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp, busy_r;
  logic [31:0] haddr, hwdata, hrdata, x;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] op, a, b, fin, v, dst, src, p;
  logic [3:0] dn, sn;
  logic [15:0] e, pc0, tgt, ret;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int busy_cnt = 0;
  integer seed = 32'h4AD5F9B7;
  logic [7:0] ops [10] = '{OP_ADD_RR, OP_ADD_RI, OP_ADD_GG, OP_ADD_GI, OP_ADD_GL,
                           OP_AND_RR, OP_AND_RI, OP_AND_GG, OP_AND_GI, OP_AND_GL};
  logic [7:0] ca [4] = '{8'h80, 8'h7F, 8'hFF, 8'h00};
  logic [7:0] cb [4] = '{8'h80, 8'h01, 8'h01, 8'h00};

  aac_host_model u_host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  aac_core #(.PROG_DEPTH(256)) u_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .busy_r(busy_r));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task summarize;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (busy_r && clk_en) busy_cnt++;
    if (cycles == 50000) begin
      fails++;
      $display("MISMATCH %0t timeout", $time);
      summarize;
    end
  end

  task wr(input logic [31:0] ad, input logic [31:0] d);
    logic [31:0] t;
    u_host.xfer(1'b1, ad, d, t);
  endtask
  task rd(input logic [31:0] ad, output logic [31:0] d);
    u_host.xfer(1'b0, ad, 32'h0, d);
  endtask
  task rw(input logic [7:0] n, input logic [7:0] d);
    wr(BUS_ADDR_REGS + {22'h0, n, 2'b00}, {24'h0, d});
  endtask
  task rr(input logic [7:0] n, output logic [7:0] d);
    logic [31:0] t;
    rd(BUS_ADDR_REGS + {22'h0, n, 2'b00}, t);
    d = t[7:0];
  endtask
  task pw(input logic [7:0] n, input logic [7:0] d);
    wr(BUS_ADDR_PROG + {22'h0, n, 2'b00}, {24'h0, d});
  endtask
  // Starts one instruction, freezes it for three cycles, then polls busy until it clears.
  task run(input logic [3:0] n);
    logic [31:0] t;
    wr(BUS_ADDR_CTRL, 32'h1);
    busy_cnt = 0;
    clk_en <= 1'b0;
    repeat (3) @(posedge hclk);
    clk_en <= 1'b1;
    `CHK(busy_r, 1'b1)
    t = 32'h1;
    while (t[0] !== 1'b0) rd(BUS_ADDR_CTRL, t);
    `CHK(busy_cnt, 32'(n))
  endtask

  // Result in the upper byte, expected flags (C Z S V in bits 7 to 4) below.
  function automatic logic [15:0] alu(input logic is_and, input logic [7:0] x1,
                                      input logic [7:0] x2, input logic [7:0] f);
    logic [8:0] s;
    s = is_and ? {f[7], x1 & x2} : {1'b0, x1} + {1'b0, x2};
    return {s[7:0], s[8], s[7:0] == 8'h00, s[7],
            ~is_and & (x1[7] == x2[7]) & (s[7] != x1[7]), 4'h0};
  endfunction

  initial begin
    hresetn = 1'b0;
    clk_en = 1'b1;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      op = ops[i % 10];
      a = (i < 20 && i % 10 < 4) ? ca[i % 10] : 8'($random(seed));
      b = (i < 20 && i % 10 < 4) ? cb[i % 10] : 8'($random(seed));
      fin = 8'($random(seed)) & 8'hF0;
      dn = 4'(i % 8);
      sn = 4'(8 + i % 8);
      dst = 8'(8'h60 + i % 16);
      src = 8'(8'h40 + i % 16);
      p = 8'(8'h20 + i % 8);
      wr(BUS_ADDR_PC, 32'h0);
      wr(BUS_ADDR_FLAGS, {24'h0, fin});
      pw(8'h00, op);
      case (op[2:0])
        3'h2: begin
          dst = WREG_BASE | {4'h0, dn};
          src = WREG_BASE | {4'h0, sn};
          pw(8'h01, {dn, sn});
        end
        3'h3: begin
          dst = WREG_BASE | {4'h0, dn};
          src = p;
          rw(WREG_BASE | {4'h0, sn}, p);
          pw(8'h01, {dn, sn});
        end
        3'h4: begin
          pw(8'h01, src);
          pw(8'h02, dst);
        end
        3'h5: begin
          rw(8'h30, src);
          pw(8'h01, 8'h30);
          pw(8'h02, dst);
        end
        default: begin
          pw(8'h01, dst);
          pw(8'h02, b);
        end
      endcase
      rw(dst, a);
      if (op[2:0] != 3'h6) rw(src, b);
      e = alu(op[6], a, b, fin);
      run(op[3:0] == 4'h2 ? CYC_SHORT : CYC_LONG);
      rr(dst, v);
      `CHK(v, e[15:8])
      if (op[2:0] != 3'h6) begin
        rr(src, v);
        `CHK(v, b)
      end
      rd(BUS_ADDR_FLAGS, x);
      `CHK(x[7:0] & 8'hF0, e[7:0])
      rr(FLAGS_ADDR, v);
      `CHK(v & 8'hF0, e[7:0])
    end
    for (int k = 0; k < 2; k++) begin
      pc0 = 16'(16'h0040 + k);
      tgt = 16'($random(seed));
      fin = 8'($random(seed)) & 8'hF0;
      wr(BUS_ADDR_PC, {16'h0, pc0});
      wr(BUS_ADDR_SP, 32'h0000_00B2);
      wr(BUS_ADDR_FLAGS, {24'h0, fin});
      pw(pc0[7:0], k ? OP_CALL_PAIR : OP_CALL_DIR);
      if (k == 1) begin
        pw(8'h41 + 8'(k), 8'h72);
        rw(8'h72, tgt[15:8]);
        rw(8'h73, tgt[7:0]);
      end else begin
        pw(8'h41, tgt[15:8]);
        pw(8'h42, tgt[7:0]);
      end
      ret = pc0 + (k ? LEN_2 : LEN_3);
      run(k ? CYC_CALL_PAIR : CYC_CALL_DIR);
      rd(BUS_ADDR_PC, x);
      `CHK(x[15:0], tgt)
      rd(BUS_ADDR_SP, x);
      `CHK(x[7:0], 8'hB0)
      rr(8'hB1, v);
      `CHK(v, ret[7:0])
      rr(8'hB0, v);
      `CHK(v, ret[15:8])
      rd(BUS_ADDR_FLAGS, x);
      `CHK(x[7:0] & 8'hF0, fin)
      wr(BUS_ADDR_PC, 32'h0000_0090);
      pw(8'h90, OP_EXIT);
      run(CYC_EXIT);
      rd(BUS_ADDR_PC, x);
      `CHK(x[15:0], ret)
      rd(BUS_ADDR_SP, x);
      `CHK(x[7:0], 8'hB2)
    end
    // A reset in mid-instruction must drop busy, keep hreadyout high and clear hrdata.
    wr(BUS_ADDR_CTRL, 32'h1);
    hresetn <= 1'b0;
    @(posedge hclk);
    `CHK(busy_r, 1'b0)
    `CHK(hreadyout, 1'b1)
    `CHK(hrdata, 32'h0)
    hresetn <= 1'b1;
    rd(BUS_ADDR_PC, x);
    `CHK(x, {16'h0000, PC_RESET})
    rd(32'h0000_0020, x);
    `CHK(x, 32'h0)
    `CHK(hresp, 1'b0)
    summarize;
  end
endmodule
